// File: hdl/arcstm_pkg.sv
package arcstm_pkg;
  localparam int STAGES = 8;
  localparam int SENSORS = 10;
  localparam int VIRTUALS = 6;
  localparam int OUTS = 5;
  localparam int TRIPS = 4;
  localparam int ALARM_BIT = 4;
  localparam int CUR_W = 10;
  localparam int TIME_W = 8;
  // Current matrix row layout
  localparam int CM_PHASE = 0;
  localparam int CM_RESID = 1;
  localparam int CM_NET = 2;
  localparam int CM_VIRT = 3;
  localparam int CM_STAGE = CM_VIRT + VIRTUALS;
  localparam int CM_W = CM_STAGE + STAGES;
  // Light matrix row layout
  localparam int LM_SENSOR = 0;
  localparam int LM_NET = SENSORS;
  localparam int LM_VIRT = LM_NET + 1;
  localparam int LM_STAGE = LM_VIRT + VIRTUALS;
  localparam int LM_W = LM_STAGE + STAGES;
  // Event signal layout
  localparam int EV_PHASE = 0;
  localparam int EV_RESID = 1;
  localparam int EV_SENSOR = 2;
  localparam int EV_STAGE = EV_SENSOR + SENSORS;
  localparam int EV_W = EV_STAGE + STAGES;
  // Thresholds in hundredths of nominal current
  localparam logic [CUR_W-1:0] PHASE_THR_MIN = 10'h032;
  localparam logic [CUR_W-1:0] PHASE_THR_MAX = 10'h320;
  localparam logic [CUR_W-1:0] RESID_THR_MIN = 10'h00a;
  localparam logic [CUR_W-1:0] RESID_THR_MAX = 10'h1f4;
  localparam logic [CUR_W-1:0] THR_DEFAULT = 10'h064;
  localparam logic [TIME_W-1:0] DELAY_DEFAULT = 8'h00;
  localparam logic [TIME_W-1:0] HOLD_MIN = 8'h02;
  localparam logic [TIME_W-1:0] HOLD_DEFAULT = 8'h02;
  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int HOLD_UNIT_MS = 10;
  localparam int DIV_W = 20;
  typedef enum logic [1:0] {
    ARCSTM_IDLE,
    ARCSTM_DELAY,
    ARCSTM_TRIP
  } arcstm_stage_type;
endpackage : arcstm_pkg

// File: hdl/arcstm_stage.sv
`timescale 1ns/1ns
module arcstm_stage (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic cond,
  input wire logic tick_ms,
  input wire logic tick_hold,
  input wire logic [arcstm_pkg::TIME_W-1:0] trip_delay,
  input wire logic [arcstm_pkg::TIME_W-1:0] min_hold,
  output logic active
);
  typedef struct packed {
    arcstm_pkg::arcstm_stage_type state;
    logic [arcstm_pkg::TIME_W-1:0] count;
    logic active;
    logic held;
  } arcstm_st_type;

  arcstm_st_type q;
  arcstm_st_type next_q;
  logic [arcstm_pkg::TIME_W-1:0] hold_eff;

  // Settings below the floor would shorten the pulse, so they are raised
  assign hold_eff = (min_hold < arcstm_pkg::HOLD_MIN) ? arcstm_pkg::HOLD_MIN
                                                       : min_hold;
  assign active = q.active;

  always_comb
  begin
    next_q = q;
    case (q.state)
      arcstm_pkg::ARCSTM_IDLE:
      begin
        next_q.count = '0;
        next_q.active = 1'b0;
        next_q.held = 1'b0;
        if (cond && trip_delay == '0)
        begin
          next_q.state = arcstm_pkg::ARCSTM_TRIP;
          next_q.active = 1'b1;
        end
        else if (cond)
          next_q.state = arcstm_pkg::ARCSTM_DELAY;
      end
      arcstm_pkg::ARCSTM_DELAY:
      begin
        if (!cond)
        begin
          next_q.state = arcstm_pkg::ARCSTM_IDLE;
          next_q.count = '0;
        end
        else if (tick_ms)
        begin
          if (q.count + 8'h01 >= trip_delay)
          begin
            next_q.state = arcstm_pkg::ARCSTM_TRIP;
            next_q.count = '0;
            next_q.active = 1'b1;
          end
          else
            next_q.count = q.count + 8'h01;
        end
      end
      arcstm_pkg::ARCSTM_TRIP:
      begin
        // The first unit may be partial, so one extra hold tick is awaited:
        // the pulse may overshoot by up to one unit but never falls short
        if (tick_hold && q.count < hold_eff)
          next_q.count = q.count + 8'h01;
        else if (tick_hold)
          next_q.held = 1'b1;
        if (!cond && q.held)
        begin
          next_q.state = arcstm_pkg::ARCSTM_IDLE;
          next_q.active = 1'b0;
          next_q.count = '0;
          next_q.held = 1'b0;
        end
      end
      default:
        next_q.state = arcstm_pkg::ARCSTM_IDLE;
    endcase
    if (!enable)
    begin
      next_q.state = arcstm_pkg::ARCSTM_IDLE;
      next_q.active = 1'b0;
      next_q.count = '0;
      next_q.held = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= '{arcstm_pkg::ARCSTM_IDLE, 8'h00, 1'b0, 1'b0};
    else
      q <= next_q;
  end

  a_stage_disable: assert property (@(posedge core_clk) disable iff (!rst_n)
    !enable |=> !active) else $error("disabled stage active");
  a_zero_delay: assert property (@(posedge core_clk) disable iff (!rst_n)
    (enable && cond && trip_delay == 8'h00 && !active) |=> active)
    else $error("zero delay did not trip");
  a_delay_restart: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!cond && !active) |=> (q.count == 8'h00 && !active))
    else $error("delay did not restart");
  a_hold_min: assert property (@(posedge core_clk) disable iff (!rst_n)
    (enable && active && !q.held) |=> active)
    else $error("trip pulse too short");
endmodule : arcstm_stage

// File: hdl/arcstm_top.sv
`timescale 1ns/1ns
module arcstm_top #(
  parameter int MS_CYCLES = arcstm_pkg::MS_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [arcstm_pkg::CUR_W-1:0] phase_current_l1,
  input wire logic [arcstm_pkg::CUR_W-1:0] phase_current_l2,
  input wire logic [arcstm_pkg::CUR_W-1:0] phase_current_l3,
  input wire logic [arcstm_pkg::CUR_W-1:0] residual_current,
  input wire logic [arcstm_pkg::CUR_W-1:0] phase_threshold,
  input wire logic [arcstm_pkg::CUR_W-1:0] residual_threshold,
  input wire logic [arcstm_pkg::SENSORS-1:0] light_sensor,
  input wire logic network_event_input,
  input wire logic [arcstm_pkg::VIRTUALS-1:0] virtual_output,
  input wire logic [arcstm_pkg::STAGES-1:0] stage_enable,
  input wire logic [arcstm_pkg::STAGES*arcstm_pkg::TIME_W-1:0] trip_delay,
  input wire logic [arcstm_pkg::STAGES*arcstm_pkg::TIME_W-1:0] min_hold,
  input wire logic [arcstm_pkg::STAGES*arcstm_pkg::CM_W-1:0] current_matrix,
  input wire logic [arcstm_pkg::STAGES*arcstm_pkg::LM_W-1:0] light_matrix,
  input wire logic [arcstm_pkg::STAGES*arcstm_pkg::OUTS-1:0] output_matrix,
  input wire logic [arcstm_pkg::OUTS-1:0] latched_mode,
  input wire logic latch_clear,
  input wire logic install_command,
  input wire logic discovery_done,
  input wire logic [arcstm_pkg::EV_W-1:0] event_signal_enable,
  input wire logic event_on_enable,
  input wire logic event_off_enable,
  output logic phase_overcurrent_flag,
  output logic residual_overcurrent_flag,
  output logic [arcstm_pkg::STAGES-1:0] stage_active,
  output logic [arcstm_pkg::TRIPS-1:0] trip_outputs,
  output logic alarm_relay,
  output logic installing,
  output logic discovery_start,
  output logic [arcstm_pkg::EV_W-1:0] event_on,
  output logic [arcstm_pkg::EV_W-1:0] event_off
);
  typedef struct packed {
    logic [arcstm_pkg::SENSORS-1:0] sync1;
    logic [arcstm_pkg::SENSORS-1:0] sync2;
    logic [arcstm_pkg::SENSORS-1:0] sync3;
    logic [arcstm_pkg::SENSORS-1:0] light;
    logic [arcstm_pkg::DIV_W-1:0] div;
    logic [3:0] ms10;
    logic tick_ms;
    logic tick_hold;
    logic phase_flag;
    logic resid_flag;
    logic [arcstm_pkg::OUTS-1:0] latch;
    logic [arcstm_pkg::OUTS-1:0] outs;
    logic installing;
    logic start;
    logic [arcstm_pkg::EV_W-1:0] prev;
    logic [arcstm_pkg::EV_W-1:0] ev_on;
    logic [arcstm_pkg::EV_W-1:0] ev_off;
  } arcstm_top_type;

  localparam logic [arcstm_pkg::DIV_W-1:0] DIV_LAST =
    arcstm_pkg::DIV_W'(MS_CYCLES - 1);
  localparam logic [3:0] MS10_LAST = 4'(arcstm_pkg::HOLD_UNIT_MS - 1);

  arcstm_top_type q;
  arcstm_top_type next_q;
  logic [arcstm_pkg::STAGES-1:0] stage_cond;
  logic [arcstm_pkg::STAGES-1:0] act;
  logic [arcstm_pkg::OUTS-1:0] drive;
  logic [arcstm_pkg::CM_W-1:0] cur_vec;
  logic [arcstm_pkg::LM_W-1:0] light_vec;
  logic [arcstm_pkg::CUR_W-1:0] phase_thr;
  logic [arcstm_pkg::CUR_W-1:0] resid_thr;
  logic [arcstm_pkg::EV_W-1:0] ev_sig;

  // Out-of-range settings are clamped to the nearest legal threshold
  assign phase_thr = (phase_threshold < arcstm_pkg::PHASE_THR_MIN) ?
    arcstm_pkg::PHASE_THR_MIN : (phase_threshold > arcstm_pkg::PHASE_THR_MAX) ?
    arcstm_pkg::PHASE_THR_MAX : phase_threshold;
  assign resid_thr = (residual_threshold < arcstm_pkg::RESID_THR_MIN) ?
    arcstm_pkg::RESID_THR_MIN :
    (residual_threshold > arcstm_pkg::RESID_THR_MAX) ?
    arcstm_pkg::RESID_THR_MAX : residual_threshold;

  assign cur_vec = {act, virtual_output, network_event_input,
                    q.resid_flag, q.phase_flag};
  assign light_vec = {act, virtual_output, network_event_input,
                      q.light};
  assign ev_sig = {act, q.light, q.resid_flag, q.phase_flag};

  genvar s;
  generate
    for (s = 0; s < arcstm_pkg::STAGES; s = s + 1)
    begin : g_stage
      logic [arcstm_pkg::CM_W-1:0] cm;
      logic [arcstm_pkg::LM_W-1:0] lm;
      logic cur_hit;
      logic light_hit;
      // A stage feeding itself would latch up, so its own column is ignored
      assign cm = current_matrix[s*arcstm_pkg::CM_W +: arcstm_pkg::CM_W]
                  & ~(arcstm_pkg::CM_W'(1) << (arcstm_pkg::CM_STAGE + s));
      assign lm = light_matrix[s*arcstm_pkg::LM_W +: arcstm_pkg::LM_W]
                  & ~(arcstm_pkg::LM_W'(1) << (arcstm_pkg::LM_STAGE + s));
      assign cur_hit = |(cm & cur_vec);
      assign light_hit = |(lm & light_vec);
      // An empty matrix imposes no condition; both empty never activates
      assign stage_cond[s] = stage_enable[s] && (|cm || |lm)
                             && (!(|cm) || cur_hit)
                             && (!(|lm) || light_hit);
      arcstm_stage u_stage (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .enable(stage_enable[s]),
        .cond(stage_cond[s]),
        .tick_ms(q.tick_ms),
        .tick_hold(q.tick_hold),
        .trip_delay(trip_delay[s*arcstm_pkg::TIME_W +: arcstm_pkg::TIME_W]),
        .min_hold(min_hold[s*arcstm_pkg::TIME_W +: arcstm_pkg::TIME_W]),
        .active(act[s])
      );
    end
  endgenerate

  always_comb
  begin
    drive = '0;
    for (int i = 0; i < arcstm_pkg::STAGES; i++)
    begin
      if (act[i])
        drive = drive | output_matrix[i*arcstm_pkg::OUTS +: arcstm_pkg::OUTS];
    end
  end

  always_comb
  begin
    next_q = q;
    // Pin synchroniser: a sensor change counts once stages two and three agree
    next_q.sync1 = light_sensor;
    next_q.sync2 = q.sync1;
    next_q.sync3 = q.sync2;
    for (int i = 0; i < arcstm_pkg::SENSORS; i++)
    begin
      if (q.sync2[i] == q.sync3[i])
        next_q.light[i] = q.sync2[i];
    end
    next_q.tick_ms = 1'b0;
    next_q.tick_hold = 1'b0;
    if (q.div == DIV_LAST)
    begin
      next_q.div = '0;
      next_q.tick_ms = 1'b1;
      if (q.ms10 == MS10_LAST)
      begin
        next_q.ms10 = '0;
        next_q.tick_hold = 1'b1;
      end
      else
        next_q.ms10 = q.ms10 + 4'h1;
    end
    else
      next_q.div = q.div + 20'h00001;
    next_q.phase_flag = (phase_current_l1 > phase_thr)
                        || (phase_current_l2 > phase_thr)
                        || (phase_current_l3 > phase_thr);
    next_q.resid_flag = residual_current > resid_thr;
    // Set wins over a clear arriving in the same cycle
    next_q.latch = (latch_clear ? '0 : q.latch)
                   | (drive & latched_mode);
    next_q.outs = drive | next_q.latch;
    next_q.start = install_command && !q.installing;
    if (install_command && !q.installing)
      next_q.installing = 1'b1;
    else if (discovery_done)
      next_q.installing = 1'b0;
    next_q.prev = ev_sig;
    next_q.ev_on = ev_sig & ~q.prev & event_signal_enable
                   & {arcstm_pkg::EV_W{event_on_enable}};
    next_q.ev_off = ~ev_sig & q.prev & event_signal_enable
                    & {arcstm_pkg::EV_W{event_off_enable}};
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= next_q;
  end

  assign phase_overcurrent_flag = q.phase_flag;
  assign residual_overcurrent_flag = q.resid_flag;
  assign stage_active = act;
  assign trip_outputs = q.outs[arcstm_pkg::TRIPS-1:0];
  assign alarm_relay = q.outs[arcstm_pkg::ALARM_BIT];
  assign installing = q.installing;
  assign discovery_start = q.start;
  assign event_on = q.ev_on;
  assign event_off = q.ev_off;

  a_trip_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
    (act[0] && output_matrix[0]) |=> trip_outputs[0])
    else $error("mapped trip not driven");
  a_latch_keep: assert property (@(posedge core_clk) disable iff (!rst_n)
    (q.latch[0] && !latch_clear) |=> trip_outputs[0])
    else $error("latched trip dropped");
  a_phase_flag: assert property (@(posedge core_clk) disable iff (!rst_n)
    (phase_current_l2 > phase_thr) |=> phase_overcurrent_flag)
    else $error("phase flag missing");
  a_install_busy: assert property (@(posedge core_clk) disable iff (!rst_n)
    (install_command && !installing) |=> (installing && discovery_start))
    else $error("install not started");
  a_event_rise: assert property (@(posedge core_clk) disable iff (!rst_n)
    ($rose(stage_active[0]) && event_on_enable
     && event_signal_enable[arcstm_pkg::EV_STAGE])
    |=> event_on[arcstm_pkg::EV_STAGE])
    else $error("stage rise event missing");
  a_event_fall: assert property (@(posedge core_clk) disable iff (!rst_n)
    ($fell(stage_active[0]) && event_off_enable
     && event_signal_enable[arcstm_pkg::EV_STAGE])
    |=> event_off[arcstm_pkg::EV_STAGE])
    else $error("stage fall event missing");
  a_event_gated: assert property (@(posedge core_clk) disable iff (!rst_n)
    !event_on_enable |=> (event_on == '0))
    else $error("event sent while disabled");
  a_ready_done: assert property (@(posedge core_clk) disable iff (!rst_n)
    (installing && discovery_done) |=> !installing)
    else $error("still installing after discovery");
endmodule : arcstm_top

// File: verification/arc_stage_trip_matrix_tb.sv
`timescale 1ns/1ns
module arc_stage_trip_matrix_tb;
  localparam int LW = arcstm_pkg::LM_W;
  localparam int CW = arcstm_pkg::CM_W;
  localparam int EVS = arcstm_pkg::EV_STAGE;
  logic core_clk, rst_n, net_in, latch_clear, inst_cmd, disc_start;
  logic disc_done, ph_flag, res_flag, installing, alarm;
  logic ev_on_en, ev_off_en;
  logic [9:0] cur1, cur2, cur3, res_cur, ph_thr, res_thr, light_cmd, light;
  logic [5:0] virt;
  logic [7:0] en, act;
  logic [63:0] td, mh;
  logic [135:0] cm;
  logic [199:0] lm;
  logic [39:0] om;
  logic [4:0] lat;
  logic [3:0] trips;
  logic [19:0] ev_en, ev_on, ev_off;
  int error_cnt, compares, n;
  logic [31:0] seed;

  arcstm_top #(.MS_CYCLES(10)) uut (
    .core_clk(core_clk), .rst_n(rst_n), .phase_current_l1(cur1),
    .phase_current_l2(cur2), .phase_current_l3(cur3),
    .residual_current(res_cur), .phase_threshold(ph_thr),
    .residual_threshold(res_thr), .light_sensor(light),
    .network_event_input(net_in), .virtual_output(virt),
    .stage_enable(en), .trip_delay(td), .min_hold(mh),
    .current_matrix(cm), .light_matrix(lm), .output_matrix(om),
    .latched_mode(lat), .latch_clear(latch_clear),
    .install_command(inst_cmd), .discovery_done(disc_done),
    .event_signal_enable(ev_en), .event_on_enable(ev_on_en),
    .event_off_enable(ev_off_en), .phase_overcurrent_flag(ph_flag),
    .residual_overcurrent_flag(res_flag), .stage_active(act),
    .trip_outputs(trips), .alarm_relay(alarm), .installing(installing),
    .discovery_start(disc_start), .event_on(ev_on), .event_off(ev_off)
  );

  arcstm_partner far_side (
    .core_clk(core_clk), .rst_n(rst_n), .discovery_start(disc_start),
    .light_cmd(light_cmd), .light_sensor(light),
    .discovery_done(disc_done)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  function automatic logic [31:0] lfsr(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr

  // Reference: each active stage ORs its output row in, latching ignored
  function automatic logic [4:0] exp_out(logic [7:0] a);
    logic [4:0] r;
    r = 5'h00;
    for (int s = 0; s < 8; s++)
      if (a[s])
        r |= om[s*5 +: 5];
    return r;
  endfunction : exp_out

  task cyc(int k);
    repeat (k) @(negedge core_clk);
  endtask : cyc

  task chk(string nm, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wait_act(int s, logic v, int lim);
    n = 0;
    while (act[s] !== v && n < lim)
    begin
      cyc(1);
      n++;
    end
  endtask : wait_act

  task close_out;
    $display("comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out

  initial
  begin
    #(8 * 40000);
    error_cnt++;
    close_out;
  end

  initial
  begin
    {cur1, cur2, cur3, res_cur, light_cmd, virt, en, td, cm, lm, om} = '0;
    {net_in, latch_clear, inst_cmd, lat} = '0;
    {ev_on_en, ev_off_en} = 2'b11;
    ph_thr = 10'h064;
    res_thr = 10'h064;
    ev_en = '1;
    mh = {8{8'h02}};
    error_cnt = 0;
    compares = 0;
    seed = 32'h71f580f9;
    rst_n = 1'b0;
    cyc(3);
    rst_n = 1'b1;
    cyc(2);
    for (int i = 0; i < 24; i++)
    begin
      seed = lfsr(seed);
      ph_thr = 10'h032 + seed[29:24];
      res_thr = 10'h00a + seed[31:24];
      cur1 = (i < 4) ? ph_thr + i[0] : {2'b00, seed[7:0]};
      cur3 = {2'b00, seed[15:8]};
      res_cur = (i < 4) ? res_thr + i[1] : {2'b00, seed[23:16]};
      cyc(2);
      chk("phase flag", cur1 > ph_thr || cur3 > ph_thr, ph_flag);
      chk("resid flag", res_cur > res_thr, res_flag);
    end
    {cur1, cur3, res_cur} = '0;
    ph_thr = 10'h064;
    res_thr = 10'h064;
    $display("test flags done");
    for (int s = 0; s < 8; s++)
    begin
      seed = lfsr(seed);
      en = 8'h01 << s;
      lm = '0;
      lm[s*LW + s] = 1'b1;
      om[s*5 +: 5] = seed[4:0] | 5'h01;
      ev_en[EVS+s] = s[0];
      ev_on_en = !s[1];
      ev_off_en = !s[2];
      light_cmd = 10'h001 << s;
      wait_act(s, 1'b1, 12);
      chk("light only", 8'h01 << s, act);
      cyc(1);
      chk("outputs", exp_out(act), {alarm, trips});
      chk("event on", ev_en[EVS+s] && ev_on_en, ev_on[EVS+s]);
      light_cmd = '0;
      wait_act(s, 1'b0, 310);
      chk("hold", 1, n >= 199);
      cyc(1);
      chk("event off", ev_en[EVS+s] && ev_off_en, ev_off[EVS+s]);
      chk("released", 0, {act, alarm, trips});
    end
    ev_en = '1;
    {ev_on_en, ev_off_en} = 2'b11;
    $display("test stages done");
    en = 8'h04;
    lm = '0;
    lm[2*LW] = 1'b1;
    cm[2*CW + arcstm_pkg::CM_PHASE] = 1'b1;
    light_cmd = 10'h001;
    cyc(20);
    chk("light no current", 0, act);
    cur2 = 10'h0c8;
    wait_act(2, 1'b1, 8);
    chk("light and current", 8'h04, act);
    en = 8'h00;
    cyc(30);
    chk("disabled", 0, {act, alarm, trips});
    en = 8'h08;
    cm[3*CW + arcstm_pkg::CM_RESID] = 1'b1;
    res_cur = 10'h0c8;
    light_cmd = '0;
    wait_act(3, 1'b1, 8);
    chk("current only", 8'h08, act);
    {res_cur, cur2, cm, lm} = '0;
    en = 8'h30;
    cm[4*CW + arcstm_pkg::CM_NET] = 1'b1;
    cm[5*CW + arcstm_pkg::CM_STAGE + 4] = 1'b1;
    lm[4*LW + arcstm_pkg::LM_VIRT + 2] = 1'b1;
    net_in = 1'b1;
    cyc(4);
    chk("net no virtual", 0, act);
    virt = 6'h04;
    wait_act(5, 1'b1, 8);
    chk("stage chain", 8'h30, act);
    {net_in, virt, cm} = '0;
    cyc(260);
    $display("test matrix done");
    // Short first burst proves the count restarts instead of pausing
    en = 8'h01;
    lm = '0;
    lm[0] = 1'b1;
    td[7:0] = 8'h03;
    light_cmd = 10'h001;
    cyc(15);
    light_cmd = '0;
    cyc(3);
    light_cmd = 10'h001;
    wait_act(0, 1'b1, 50);
    chk("delay", 1, n >= 20 && n <= 36);
    light_cmd = '0;
    wait_act(0, 1'b0, 400);
    chk("min hold", 1, n >= 200 && n <= 302);
    td = '0;
    om[4:0] = 5'h11;
    lat = 5'h01;
    light_cmd = 10'h001;
    wait_act(0, 1'b1, 12);
    light_cmd = '0;
    cyc(310);
    chk("latched", 5'h01, {alarm, trips});
    latch_clear = 1'b1;
    cyc(1);
    latch_clear = 1'b0;
    cyc(2);
    chk("cleared", 0, {alarm, trips});
    $display("test timing done");
    inst_cmd = 1'b1;
    cyc(1);
    inst_cmd = 1'b0;
    chk("installing", 2'b11, {installing, disc_start});
    n = 0;
    while (installing === 1'b1 && n < 30)
    begin
      cyc(1);
      n++;
    end
    chk("ready", 0, installing);
    $display("test install done");
    close_out;
  end
endmodule : arc_stage_trip_matrix_tb

// File: verification/arcstm_partner.sv
`timescale 1ns/1ns
module arcstm_partner #(
  parameter int DISC_CYCLES = 6
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic discovery_start,
  input wire logic [arcstm_pkg::SENSORS-1:0] light_cmd,
  output logic [arcstm_pkg::SENSORS-1:0] light_sensor,
  output logic discovery_done
);
  int cnt;
  // Optical pins carry no timing of their own; the bench sets the pattern
  assign light_sensor = light_cmd;
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
    begin
      cnt <= 0;
      discovery_done <= 1'b0;
    end
    else
    begin
      discovery_done <= (cnt == 1);
      if (discovery_start)
        cnt <= DISC_CYCLES;
      else if (cnt != 0)
        cnt <= cnt - 1;
    end
endmodule : arcstm_partner
